// >>> logic/rlyc_pkg.sv
// Package of constants and types for the relay channel controller
package rlyc_pkg;
	localparam int NUM_CH = 8;
	localparam int FRAME_BITS = 16;
	localparam int SCLK_MAX_KHZ = 5000;
	localparam int CLK_MHZ = 100;
	localparam int RESTART_TIME_US = 50;
	localparam int RESTART_CYCLES = RESTART_TIME_US * CLK_MHZ;
	localparam int PWM_PERIOD_CYCLES = 4096;
	// Frame layout: [15:14] command, [13:11] sub address, [7:0] data
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 14;
	localparam int SUB_MSB = 13;
	localparam int SUB_LSB = 11;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_CLEAR = 2'h3;
	localparam logic [2:0] SUB_ENABLE = 3'h0;
	localparam logic [2:0] SUB_MAP0 = 3'h1;
	localparam logic [2:0] SUB_MAP1 = 3'h2;
	localparam logic [2:0] SUB_PWM0_DUTY = 3'h3;
	localparam logic [2:0] SUB_PWM1_DUTY = 3'h4;
	localparam logic [2:0] SUB_PWM0_MAP = 3'h5;
	localparam logic [2:0] SUB_PWM1_MAP = 3'h6;
	localparam logic [2:0] SUB_PROBE = 3'h7;
	localparam logic [7:0] MAP0_RESET = 8'h04;
	localparam logic [7:0] MAP1_RESET = 8'h08;
	localparam logic [7:0] LIMP_MAP0 = 8'h04;
	localparam logic [7:0] LIMP_MAP1 = 8'h08;
	localparam logic [7:0] HIGH_SIDE_MASK = 8'hfc;
	typedef struct packed {
		logic [7:0] overload;
		logic [7:0] overtemp;
		logic [7:0] open_on;
	} rlyc_fault_t;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
	} rlyc_spi_t;
endpackage

// >>> logic/rlyc_pwm.sv
// Free-running PWM generator with programmable duty
`timescale 1ns/1ps
module rlyc_pwm #(
	parameter int PERIOD = rlyc_pkg::PWM_PERIOD_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] duty_in,
	output logic pwm_out
);
	import rlyc_pkg::*;
	localparam int CW = $clog2(PERIOD);
	logic [CW-1:0] cnt_reg;
	logic [7:0] phase;
	// Period counter
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cnt_reg <= '0;
		else if (cnt_reg == CW'(PERIOD - 1))
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 1'b1;
	end
	assign phase = cnt_reg[CW-1 -: 8];
	// Duty compare
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			pwm_out <= 1'b0;
		else
			pwm_out <= (phase < duty_in);
	end
endmodule

// >>> logic/rlyc_top.sv
// Control, protection and serial logic of the eight-channel switch
// How it works
// - Serial frames are sixteen bits
// - Shift-through output, but chained frames over sixteen clocks are refused
// - Serial port idle without digital supply
// - Inputs drive channels two, three by default
// - Writable input map drives many channels
// - Limp home routes inputs to channels 2,3
// - Idle low lets inputs switch fail-safe channels
// - Overload latches channel off until cleared
// - Limp home restarts overloaded channel after time
// - Overtemperature latches channel off
// - Open-load faults latched until read
// - Probe current enable, output level monitor
// - On-state open load only high side
// - Two internal PWM generators
// - Eight individually switched channels
// - Serial output released while select high
// - Input zero to two, one to three
// - Idle pin high selects idle mode
`timescale 1ns/1ps
module rlyc_top #(
	parameter int RESTART_CNT = rlyc_pkg::RESTART_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic vdd_ok_in,
	input wire rlyc_pkg::rlyc_spi_t spi_in,
	output logic miso_out,
	output logic miso_oe_n_out,
	input wire logic parallel_input_zero_in,
	input wire logic parallel_input_one_in,
	input wire logic idle_pin_in,
	input wire logic limp_home_in,
	input wire rlyc_pkg::rlyc_fault_t fault_in,
	input wire logic [7:0] output_level_in,
	output logic [7:0] drive_out,
	output logic [7:0] probe_en_out,
	output logic idle_mode_out
);
	import rlyc_pkg::*;
	localparam int RW = $clog2(RESTART_CNT + 1);
	// Three-stage samplers for pins
	logic [5:0] s1_reg, s2_reg, s3_reg;
	logic [5:0] raw;
	logic [5:0] filt_reg;
	assign raw = {spi_in.cs_n, spi_in.sclk, spi_in.mosi, parallel_input_zero_in, parallel_input_one_in, idle_pin_in};
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s1_reg <= 6'h20;
			s2_reg <= 6'h20;
			s3_reg <= 6'h20;
			filt_reg <= 6'h20;
		end
		else
		begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < 6; i++)
				if (s2_reg[i] == s3_reg[i])
					filt_reg[i] <= s3_reg[i];
		end
	end
	logic cs_n, sclk, mosi, in0, in1, idle;
	assign {cs_n, sclk, mosi, in0, in1, idle} = filt_reg;
	logic sclk_d_reg;
	logic sclk_rise, sclk_fall, spi_act;
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			sclk_d_reg <= 1'b0;
		else
			sclk_d_reg <= sclk;
	end
	assign spi_act = vdd_ok_in && !cs_n;
	assign sclk_rise = spi_act && sclk && !sclk_d_reg;
	assign sclk_fall = spi_act && !sclk && sclk_d_reg;
	// Serial shift register, frame counter and answer word
	logic [FRAME_BITS-1:0] sh_reg;
	logic [4:0] bit_cnt_reg;
	logic cs_d_reg;
	logic frame_end;
	logic [FRAME_BITS-1:0] answer;
	logic [2:0] rd_sel_reg;
	logic [7:0] en_reg, map0_reg, map1_reg, pwm0_duty_reg, pwm1_duty_reg, pwm0_map_reg, pwm1_map_reg, probe_reg;
	logic [7:0] ovl_reg, otp_reg, ol_reg, ovl_seen_reg;
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cs_d_reg <= 1'b1;
		else
			cs_d_reg <= cs_n;
	end
	// Frame ends on select rising with exactly sixteen clocks
	assign frame_end = vdd_ok_in && cs_n && !cs_d_reg && bit_cnt_reg == 5'(FRAME_BITS);
	always_comb
	begin
		case (rd_sel_reg)
			3'h0: answer = {8'h00, ovl_reg};
			3'h1: answer = {8'h00, otp_reg};
			3'h2: answer = {8'h00, ol_reg};
			3'h3: answer = {8'h00, output_level_in};
			3'h4: answer = {8'h00, en_reg};
			default: answer = {5'h00, idle_mode_out, in1, in0, map0_reg};
		endcase
	end
	// Shift in on rising, out on falling; first bit out is answer MSB
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sh_reg <= '0;
			bit_cnt_reg <= '0;
		end
		else if (!vdd_ok_in || cs_n)
			bit_cnt_reg <= '0;
		else if (cs_d_reg)
			sh_reg <= answer;
		else if (sclk_rise)
		begin
			sh_reg <= {sh_reg[FRAME_BITS-2:0], mosi};
			if (bit_cnt_reg != 5'h1f)
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end
	// Serial output: high-z while select high
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			miso_out <= 1'b0;
			miso_oe_n_out <= 1'b1;
		end
		else
		begin
			miso_oe_n_out <= !spi_act;
			if (!spi_act)
				miso_out <= 1'b0;
			else if (cs_d_reg)
				miso_out <= answer[FRAME_BITS-1];
			else if (sclk_fall)
				miso_out <= sh_reg[FRAME_BITS-1];
		end
	end
	logic [1:0] cmd;
	logic [2:0] sub;
	logic [7:0] dat;
	assign cmd = sh_reg[CMD_MSB:CMD_LSB];
	assign sub = sh_reg[SUB_MSB:SUB_LSB];
	assign dat = sh_reg[7:0];
	// Configuration registers, reset on supply loss
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			en_reg <= '0;
			map0_reg <= MAP0_RESET;
			map1_reg <= MAP1_RESET;
			pwm0_duty_reg <= '0;
			pwm1_duty_reg <= '0;
			pwm0_map_reg <= '0;
			pwm1_map_reg <= '0;
			probe_reg <= '0;
			rd_sel_reg <= '0;
		end
		else if (!vdd_ok_in)
		begin
			en_reg <= '0;
			map0_reg <= MAP0_RESET;
			map1_reg <= MAP1_RESET;
			pwm0_duty_reg <= '0;
			pwm1_duty_reg <= '0;
			pwm0_map_reg <= '0;
			pwm1_map_reg <= '0;
			probe_reg <= '0;
			rd_sel_reg <= '0;
		end
		else if (frame_end)
		begin
			if (cmd == CMD_READ)
				rd_sel_reg <= sub;
			else if (cmd == CMD_WRITE)
				case (sub)
					SUB_ENABLE: en_reg <= dat;
					SUB_MAP0: map0_reg <= dat;
					SUB_MAP1: map1_reg <= dat;
					SUB_PWM0_DUTY: pwm0_duty_reg <= dat;
					SUB_PWM1_DUTY: pwm1_duty_reg <= dat;
					SUB_PWM0_MAP: pwm0_map_reg <= dat;
					SUB_PWM1_MAP: pwm1_map_reg <= dat;
					default: probe_reg <= dat;
				endcase
		end
	end
	logic clr_ovl, rd_ovl;
	assign clr_ovl = frame_end && cmd == CMD_CLEAR;
	// Open-load latch clears only after its contents went out in a frame
	assign rd_ovl = frame_end && rd_sel_reg == 3'h2;
	// Limp home retry timer per channel
	logic [7:0] retry_fire;
	logic [7:0] limp_src;
	assign limp_src = ({8{in0}} & LIMP_MAP0) | ({8{in1}} & LIMP_MAP1);
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			logic [RW-1:0] rt_reg;
			always_ff @(posedge ref_clk_in or negedge rstn_in)
			begin
				if (!rstn_in)
					rt_reg <= '0;
				else if (!(limp_home_in && ovl_reg[g] && limp_src[g]))
					rt_reg <= '0;
				else if (rt_reg != RW'(RESTART_CNT))
					rt_reg <= rt_reg + 1'b1;
			end
			assign retry_fire[g] = rt_reg == RW'(RESTART_CNT);
		end
	endgenerate
	// Protection latches, set wins over clear
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ovl_reg <= '0;
			otp_reg <= '0;
			ol_reg <= '0;
		end
		else
		begin
			ovl_reg <= fault_in.overload | (ovl_reg & ~(clr_ovl ? 8'hff : retry_fire));
			otp_reg <= fault_in.overtemp | (otp_reg & ~(clr_ovl ? 8'hff : 8'h00));
			ol_reg <= (fault_in.open_on & HIGH_SIDE_MASK & drive_out) | (ol_reg & ~(rd_ovl ? 8'hff : 8'h00));
		end
	end
	// Two internal PWM generators
	logic pwm0, pwm1;
	rlyc_pwm u_pwm0 (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .duty_in(pwm0_duty_reg), .pwm_out(pwm0));
	rlyc_pwm u_pwm1 (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .duty_in(pwm1_duty_reg), .pwm_out(pwm1));
	logic [7:0] req;
	always_comb
	begin
		if (limp_home_in)
			req = limp_src;
		else
			req = en_reg | ({8{in0}} & map0_reg) | ({8{in1}} & map1_reg)
				| ({8{pwm0}} & pwm0_map_reg) | ({8{pwm1}} & pwm1_map_reg);
	end
	// Next drive word, so the probe never overlaps a driven channel
	logic [7:0] drive_next;
	assign drive_next = req & ~ovl_reg & ~otp_reg & ~fault_in.overload & ~fault_in.overtemp;
	// Registered outputs
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			drive_out <= '0;
			probe_en_out <= '0;
			idle_mode_out <= 1'b0;
		end
		else
		begin
			drive_out <= drive_next;
			probe_en_out <= probe_reg & ~drive_next;
			idle_mode_out <= idle;
		end
	end
	a_miso_hiz: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!spi_act |=> miso_oe_n_out) else $error("serial out driven while deselected");
	a_ovl_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		fault_in.overload != 8'h00 |=> (drive_out & $past(fault_in.overload)) == 8'h00
		&& (ovl_reg & $past(fault_in.overload)) == $past(fault_in.overload))
		else $error("overload not latched");
	a_otp_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		otp_reg != 8'h00 |=> (drive_out & $past(otp_reg)) == 8'h00) else $error("hot channel driven");
	a_limp_map: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		limp_home_in && ovl_reg == 8'h00 && otp_reg == 8'h00 && fault_in == '0 |=> drive_out == $past(limp_src))
		else $error("limp routing wrong");
	a_supply_rst: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!vdd_ok_in |=> map0_reg == MAP0_RESET && en_reg == 8'h00) else $error("config kept without supply");
	a_ol_hs: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(ol_reg & ~HIGH_SIDE_MASK) == 8'h00) else $error("low side open load flagged");
	a_idle_follow: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		1'b1 |=> idle_mode_out == $past(idle)) else $error("idle mode mismatch");
	a_probe_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(probe_en_out & drive_out) == 8'h00) else $error("probe on driven channel");
	c_frame: cover property (@(posedge ref_clk_in) frame_end);
	c_limp_retry: cover property (@(posedge ref_clk_in) retry_fire != 8'h00);
	c_pwm_drive: cover property (@(posedge ref_clk_in) pwm0 && pwm0_map_reg != 8'h00);
	c_diag_read: cover property (@(posedge ref_clk_in) rd_ovl && ol_reg != 8'h00);
endmodule

// >>> test/rlyc_spi_host.sv
// Serial master model that frames traffic for the channel controller
`timescale 1ns/1ps
module rlyc_spi_host (
	input wire logic ref_clk_in,
	input wire logic miso_in,
	output rlyc_pkg::rlyc_spi_t spi_out
);
	import rlyc_pkg::*;
	// Idle bus: select high, clock parked low, data pulled down
	initial spi_out = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
	// One select period of n clocks, MSB first, serial clock period 80 ns
	// Bench clock rate set by the sampler's eight-cycle floor, not the host limit
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		int i;
		rx = '0;
		@(posedge ref_clk_in);
		spi_out.cs_n <= 1'b0;
		spi_out.mosi <= tx[31];
		repeat (8) @(posedge ref_clk_in);
		for (i = 0; i < n; i++)
		begin
			repeat (4) @(posedge ref_clk_in);
			spi_out.sclk <= 1'b1;
			repeat (4) @(posedge ref_clk_in);
			rx = {rx[30:0], miso_in}; // Last moment before the bit changes
			spi_out.sclk <= 1'b0;
			spi_out.mosi <= (i < 31) ? tx[30 - i] : 1'b0;
		end
		repeat (4) @(posedge ref_clk_in);
		spi_out.cs_n <= 1'b1;
		spi_out.mosi <= 1'b0;
		repeat (12) @(posedge ref_clk_in); // Select gap well over 100 ns
	endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the relay channel controller
`timescale 1ns/1ps
module tb;
	import rlyc_pkg::*;
	localparam int RST_CNT = 20;
	logic ref_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic vdd_ok = 1'b1;
	logic in0 = 1'b0;
	logic in1 = 1'b0;
	logic idle_pin = 1'b0;
	logic limp = 1'b0;
	rlyc_fault_t fault = '0;
	logic [7:0] level = 8'h5a;
	rlyc_spi_t spi;
	logic miso;
	logic miso_oe_n;
	logic idle_mode;
	logic [7:0] drive;
	logic [7:0] probe_en;
	logic [31:0] rx;
	int errors = 0;
	int tests_run = 0;
	int g;
	int ones;

	// Clock
	always #5 ref_clk_in = ~ref_clk_in;

	// Device and serial master
	rlyc_top #(.RESTART_CNT(RST_CNT)) dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .vdd_ok_in(vdd_ok),
		.spi_in(spi), .miso_out(miso), .miso_oe_n_out(miso_oe_n), .parallel_input_zero_in(in0),
		.parallel_input_one_in(in1), .idle_pin_in(idle_pin), .limp_home_in(limp), .fault_in(fault),
		.output_level_in(level), .drive_out(drive), .probe_en_out(probe_en), .idle_mode_out(idle_mode));
	rlyc_spi_host host (.ref_clk_in(ref_clk_in), .miso_in(miso), .spi_out(spi));

	// Shared helpers
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] fr(input logic [1:0] c, input logic [2:0] s, input logic [7:0] d);
		return {c, s, 3'h0, d, 16'h0000};
	endfunction
	task automatic wr(input logic [1:0] c, input logic [2:0] s, input logic [7:0] d);
		host.xfer(fr(c, s, d), 16, rx);
		tick(8);
	endtask
	task automatic complete_run();
		$display("Mismatches %0d of %0d checks", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Reset state, idle pin
	task automatic t_reset();
		chk(drive, 8'h00);
		chk(miso_oe_n, 1'b1);
		idle_pin <= 1'b1;
		tick(10);
		chk(idle_mode, 1'b1);
		idle_pin <= 1'b0;
		tick(10);
	endtask

	// Default and programmed input mapping, limp home override
	task automatic t_map();
		in0 <= 1'b1;
		tick(10);
		chk(drive, 8'h04);
		in0 <= 1'b0;
		in1 <= 1'b1;
		tick(10);
		chk(drive, 8'h08);
		in1 <= 1'b0;
		wr(CMD_WRITE, SUB_MAP0, 8'h31);
		in0 <= 1'b1;
		tick(10);
		chk(drive, 8'h31);
		limp <= 1'b1;
		tick(6);
		chk(drive, 8'h04);
		limp <= 1'b0;
		in0 <= 1'b0;
		wr(CMD_WRITE, SUB_MAP0, MAP0_RESET);
	endtask

	// Enable bits, short frame refused, chained frame shifts through
	task automatic t_frame();
		wr(CMD_WRITE, SUB_ENABLE, 8'ha5);
		chk(drive, 8'ha5);
		in1 <= 1'b1;
		tick(10);
		chk(drive, 8'had);
		in1 <= 1'b0;
		host.xfer(fr(CMD_WRITE, SUB_ENABLE, 8'hff), 15, rx);
		tick(8);
		chk(drive, 8'ha5);
		host.xfer(fr(CMD_WRITE, SUB_ENABLE, 8'h5a), 32, rx);
		tick(8);
		chk(rx[15:0], 16'(fr(CMD_WRITE, SUB_ENABLE, 8'h5a) >> 16));
		chk(drive, 8'ha5);
		chk(miso_oe_n, 1'b1);
	endtask

	// Overload and thermal latches, clear frame, limp home restart
	task automatic t_latch();
		wr(CMD_WRITE, SUB_ENABLE, 8'h03);
		fault.overload[0] <= 1'b1;
		tick(1);
		fault.overtemp[1] <= 1'b1;
		tick(1);
		fault <= '0;
		tick(10);
		chk(drive, 8'h00);
		wr(CMD_CLEAR, 3'h0, 8'hff);
		chk(drive, 8'h03);
		wr(CMD_WRITE, SUB_ENABLE, 8'h00);
		limp <= 1'b1;
		in0 <= 1'b1;
		tick(10);
		fault.overload[2] <= 1'b1;
		tick(1);
		fault <= '0;
		tick(8);
		chk(drive, 8'h00);
		tick(RST_CNT + 10);
		chk(drive, 8'h04);
		limp <= 1'b0;
		in0 <= 1'b0;
	endtask

	// Probe current and both PWM generators
	task automatic t_pwm();
		wr(CMD_WRITE, SUB_PROBE, 8'h30);
		chk(probe_en, 8'h30);
		for (g = 0; g < 2; g++)
		begin
			wr(CMD_WRITE, g ? SUB_PWM1_DUTY : SUB_PWM0_DUTY, 8'h80);
			wr(CMD_WRITE, g ? SUB_PWM1_MAP : SUB_PWM0_MAP, 8'h01);
			ones = 0;
			repeat (PWM_PERIOD_CYCLES)
			begin
				tick(1);
				ones += (drive[0] === 1'b1);
			end
			chk(16'(ones), 16'(PWM_PERIOD_CYCLES / 2));
			wr(CMD_WRITE, g ? SUB_PWM1_MAP : SUB_PWM0_MAP, 8'h00);
		end
	endtask

	// Latched diagnosis read back, level monitor, clear after read
	task automatic t_diag();
		wr(CMD_WRITE, SUB_ENABLE, 8'h05);
		level <= 8'hc3;
		fault.open_on <= 8'h05;
		tick(1);
		fault <= '0;
		wr(CMD_READ, 3'h2, 8'h00);
		wr(CMD_READ, 3'h3, 8'h00);
		chk(rx[15:0], 16'h0004);
		wr(CMD_READ, 3'h2, 8'h00);
		chk(rx[15:0], {8'h00, level});
		wr(CMD_READ, 3'h0, 8'h00);
		chk(rx[15:0], 16'h0000);
		wr(CMD_WRITE, SUB_ENABLE, 8'h00);
	endtask

	// Supply loss: traffic ignored, configuration back to default
	task automatic t_supply();
		wr(CMD_WRITE, SUB_ENABLE, 8'h81);
		wr(CMD_WRITE, SUB_MAP1, 8'h40);
		vdd_ok <= 1'b0;
		tick(10);
		chk(drive, 8'h00);
		wr(CMD_WRITE, SUB_ENABLE, 8'hff);
		chk(drive, 8'h00);
		in0 <= 1'b1;
		tick(10);
		chk(drive, 8'h04);
		in0 <= 1'b0;
		vdd_ok <= 1'b1;
		in1 <= 1'b1;
		tick(10);
		chk(drive, 8'h08);
	endtask

	// Main sequence
	initial
	begin
		tick(20);
		rstn_in <= 1'b1;
		tick(8);
		t_reset();
		t_map();
		t_frame();
		t_latch();
		t_pwm();
		t_diag();
		t_supply();
		complete_run();
	end

	// Watchdog
	initial
	begin
		#300000; // About two and a half times the planned run of some twelve thousand cycles
		errors++;
		complete_run();
	end
endmodule
